// >>> rtl/adaptive_fir_7tap.v
// How it works
// - output sums seven delayed samples times seven coefficients, 20 bits
// - format select low means two's complement input, high means binary
// - samples are captured on each falling sample clock edge while the result buffer has room
// - coefficients are sign bit plus eight magnitude bits
// - coefficient taken on falling load clock edge while load enable high
// - tap outputs are two's complement whatever the input format
// - tap outputs change on falling sample clock edges
// - 20-bit two's complement result queued on falling sample clock edges into a two-word buffer, popped by result_ready
// - delayed copy of input, unchanged format, for cascading
// - result appears eleven sample edges after its newest sample enters
// - tap latencies: first 3, fourth 4, seventh 9, delayed copy 9
`timescale 1ns/100ps
`default_nettype none
`include "adaptive_fir_7tap_map.vh"

module adaptive_fir_7tap #(
    parameter TAPS = `FIR_TAPS
) (
    input wire core_clk,
    input wire rst,
    input wire sample_clock,
    input wire [`FIR_SAMPLE_MSB:0] sample_in,
    input wire format_select,
    input wire load_clock,
    input wire load_enable,
    input wire [`FIR_COEF_W-1:0] coef_in,
    input wire result_ready,
    output wire sample_ready,
    output reg [`FIR_SAMPLE_MSB:0] tap_out_first,
    output reg [`FIR_SAMPLE_MSB:0] tap_out_fourth,
    output reg [`FIR_SAMPLE_MSB:0] tap_out_seventh,
    output reg [`FIR_SAMPLE_MSB:0] delayed_sample_out,
    output wire [`FIR_RESULT_W-1:0] result_out,
    output wire result_valid
);

    // ------------------------------------------------------------
    // sizing
    // ------------------------------------------------------------
    // window starts here so prod lands at 10 and buffer at 11
    localparam WIN = `FIR_LAT_RESULT - 2;
    localparam DEPTH = WIN + TAPS;
    localparam PROD_W = `FIR_SAMPLE_W + `FIR_COEF_W + 1;

    // ------------------------------------------------------------
    // format helpers
    // ------------------------------------------------------------
    // straight binary is offset by half scale: flip the top bit
    function [`FIR_SAMPLE_MSB:0] to_twos;
        input [`FIR_SAMPLE_MSB:0] s;
        input binary;
        begin
            to_twos = binary ? {~s[`FIR_SAMPLE_MSB], s[`FIR_SAMPLE_MSB-1:0]}
                             : s;
        end
    endfunction

    // sign plus magnitude to two's complement, one bit wider
    function [`FIR_COEF_W:0] coef_value;
        input [`FIR_COEF_W-1:0] c;
        reg [`FIR_COEF_W:0] mag;
        begin
            mag = {2'b00, c[`FIR_COEF_MAG_MSB:0]};
            coef_value = c[`FIR_COEF_SIGN] ? (~mag + 1'b1) : mag;
        end
    endfunction

    // ------------------------------------------------------------
    // edge detection on the slow pins
    // ------------------------------------------------------------
    reg sclk_prev;
    reg lclk_prev;
    wire sample_fall;
    wire load_fall;
    wire advance;
    wire buf_ready;

    // pins are synchronous to core_clk, so one flop suffices
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b0;
            lclk_prev <= 1'b0;
        end else begin
            sclk_prev <= sample_clock;
            lclk_prev <= load_clock;
        end
    end

    assign sample_fall = sclk_prev & ~sample_clock;
    assign load_fall = lclk_prev & ~load_clock;
    // a full result buffer freezes the whole pipeline, no word dropped
    assign advance = sample_fall & buf_ready;
    assign sample_ready = buf_ready;

    // ------------------------------------------------------------
    // sample delay line and coefficient chain
    // ------------------------------------------------------------
    reg [`FIR_SAMPLE_MSB:0] line [0:DEPTH-1];
    // format bit per sample, so a select change never rereads old samples
    reg fmt_line [0:DEPTH-1];
    reg [`FIR_COEF_W-1:0] coef [0:TAPS-1];
    reg signed [PROD_W-1:0] prod [0:TAPS-1];

    // raw samples kept so the cascade copy keeps its format
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line[0] <= `FIR_SAMPLE_RESET;
            fmt_line[0] <= 1'b0;
        end else if (advance) begin
            line[0] <= sample_in;
            fmt_line[0] <= format_select;
        end
    end

    // coefficients are live: reloading never pauses filtering
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            coef[0] <= `FIR_COEF_RESET;
        end else if (load_fall && load_enable) begin
            coef[0] <= coef_in;
        end
    end

    genvar i;
    generate
        for (i = 1; i < DEPTH; i = i + 1) begin : g_line
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    line[i] <= `FIR_SAMPLE_RESET;
                    fmt_line[i] <= 1'b0;
                end else if (advance) begin
                    line[i] <= line[i-1];
                    fmt_line[i] <= fmt_line[i-1];
                end
            end
        end
        for (i = 1; i < TAPS; i = i + 1) begin : g_coef
            // shift only on enabled load edges, otherwise hold
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    coef[i] <= `FIR_COEF_RESET;
                end else if (load_fall && load_enable) begin
                    coef[i] <= coef[i-1];
                end
            end
        end
        for (i = 0; i < TAPS; i = i + 1) begin : g_prod
            // one registered multiply per tap keeps the adder tree short
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    prod[i] <= {PROD_W{1'b0}};
                end else if (advance) begin
                    prod[i] <= $signed(to_twos(line[WIN+i],
                        fmt_line[WIN+i]))
                        * $signed(coef_value(coef[i]));
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // adder
    // ------------------------------------------------------------
    reg signed [`FIR_RESULT_W-1:0] sum;
    integer k;

    // worst case 7 * 256 * 255 still fits in 20 bits
    always @* begin
        sum = {`FIR_RESULT_W{1'b0}};
        for (k = 0; k < TAPS; k = k + 1) begin
            sum = sum + {{(`FIR_RESULT_W-PROD_W){prod[k][PROD_W-1]}},
                prod[k]};
        end
    end

    // ------------------------------------------------------------
    // tap and cascade outputs
    // ------------------------------------------------------------
    // output on edge L holds line[L-1], i.e. L edges after capture
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tap_out_first <= `FIR_SAMPLE_RESET;
            tap_out_fourth <= `FIR_SAMPLE_RESET;
            tap_out_seventh <= `FIR_SAMPLE_RESET;
            delayed_sample_out <= `FIR_SAMPLE_RESET;
        end else if (advance) begin
            tap_out_first <= to_twos(line[`FIR_LAT_FIRST-1],
                fmt_line[`FIR_LAT_FIRST-1]);
            tap_out_fourth <= to_twos(line[`FIR_LAT_FOURTH-1],
                fmt_line[`FIR_LAT_FOURTH-1]);
            tap_out_seventh <= to_twos(line[`FIR_LAT_SEVENTH-1],
                fmt_line[`FIR_LAT_SEVENTH-1]);
            delayed_sample_out <= line[`FIR_LAT_DELAYED-1];
        end
    end

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    // sum enters on the sample edge: prod at 10, buffer head at 11
    result_buffer2 #(
        .WIDTH(`FIR_RESULT_W)
    ) u_result_buffer (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(advance),
        .in_data(sum),
        .in_ready(buf_ready),
        .out_valid(result_valid),
        .out_data(result_out),
        .out_ready(result_ready)
    );

endmodule

`default_nettype wire

// >>> common/adaptive_fir_7tap_map.vh
`ifndef ADAPTIVE_FIR_7TAP_MAP_VH
`define ADAPTIVE_FIR_7TAP_MAP_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define FIR_TAPS 7
`define FIR_SAMPLE_W 9
`define FIR_COEF_W 9
`define FIR_RESULT_W 20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FIR_SAMPLE_MSB 8
`define FIR_COEF_SIGN 8
`define FIR_COEF_MAG_MSB 7

// ----------------------------------------------------------------
// latencies in sample clock falling edges
// ----------------------------------------------------------------
`define FIR_LAT_FIRST 3
`define FIR_LAT_FOURTH 4
`define FIR_LAT_SEVENTH 9
`define FIR_LAT_DELAYED 9
`define FIR_LAT_RESULT 11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FIR_SAMPLE_RESET 9'h000
`define FIR_COEF_RESET 9'h000
`define FIR_RESULT_RESET 20'h00000

`endif

// >>> rtl/result_buffer2.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// two-entry buffer, all outputs registered
// ----------------------------------------------------------------
module result_buffer2 #(
    parameter WIDTH = 20
) (
    input wire core_clk,
    input wire rst,
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output reg in_ready,
    output reg out_valid,
    output reg [WIDTH-1:0] out_data,
    input wire out_ready
);

    reg [WIDTH-1:0] spare;
    reg [1:0] count;
    reg [1:0] next_count;
    wire push;
    wire pop;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // occupancy after this cycle
    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 2'd1;
        end else if (pop && !push) begin
            next_count = count - 2'd1;
        end
    end

    // head lives in out_data so the output is a plain flop
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= 2'd0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
            spare <= {WIDTH{1'b0}};
        end else begin
            count <= next_count;
            in_ready <= (next_count != 2'd2);
            out_valid <= (next_count != 2'd0);
            if (push && !pop) begin
                if (count == 2'd0) begin
                    out_data <= in_data;
                end else begin
                    spare <= in_data;
                end
            end else if (pop && !push) begin
                out_data <= spare;
            end else if (pop && push) begin
                if (count == 2'd1) begin
                    out_data <= in_data;
                end else begin
                    out_data <= spare;
                    spare <= in_data;
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> test/adaptive_fir_7tap_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// port watcher for the filter
// ----------------------------------------------------------------
module adaptive_fir_7tap_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sample_clock,
    input wire logic result_ready,
    input wire logic sample_ready,
    input wire logic [8:0] tap_out_first,
    input wire logic [8:0] tap_out_fourth,
    input wire logic [8:0] delayed_sample_out,
    input wire logic [19:0] result_out,
    input wire logic result_valid
);
    logic prev_sc;
    wire fall = prev_sc & ~sample_clock;
    wire ev = fall & sample_ready;
    // mirrors the design's edge detector, cleared the same way
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            prev_sc <= 1'b0;
        else
            prev_sc <= sample_clock;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_rst;
        $fell(rst) |-> !result_valid && sample_ready && tap_out_first == 0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad state after reset");
    property p_hold;
        !ev |=> $stable(tap_out_first) && $stable(tap_out_fourth);
    endproperty
    a_hold: assert property (p_hold) else $error("taps moved");
    property p_shift;
        ev |=> tap_out_fourth == $past(tap_out_first);
    endproperty
    a_shift: assert property (p_shift) else $error("tap chain");
    property p_res_hold;
        result_valid && !result_ready |=> result_valid && $stable(result_out);
    endproperty
    a_res_hold: assert property (p_res_hold)
        else $error("result lost");
    property p_refuse;
        fall && !sample_ready |=> $stable(delayed_sample_out);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused fall");
    property p_push;
        ev && !result_valid |=> result_valid;
    endproperty
    a_push: assert property (p_push) else $error("no push");
    property p_no_pop;
        !result_valid && !ev |=> !result_valid;
    endproperty
    a_no_pop: assert property (p_no_pop) else $error("stray word");
    property p_refill;
        !sample_ready && result_ready |-> ##[1:2] sample_ready;
    endproperty
    a_refill: assert property (p_refill) else $error("stuck full");
endmodule
bind adaptive_fir_7tap adaptive_fir_7tap_chk u_chk (.core_clk, .rst,
    .sample_clock, .result_ready, .sample_ready, .tap_out_first,
    .tap_out_fourth, .delayed_sample_out, .result_out, .result_valid);
`default_nettype wire

// >>> test/result_sink.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// downstream word taker, stalls on command
// ----------------------------------------------------------------
module result_sink (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic stall,
    output logic result_ready
);
    // registered, so a stall lands one edge late as real logic would
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            result_ready <= 1'b0;
        else
            result_ready <= !stall;
    end
endmodule
`default_nettype wire

// >>> test/tb_adaptive_fir_7tap.sv
`timescale 1ns/100ps
`default_nettype none
module tb_adaptive_fir_7tap;
    logic core_clk = 0, rst = 1, sample_clock = 0, format_select = 0;
    logic load_clock = 0, load_enable = 0, stall = 0;
    logic [8:0] sample_in = 9'h000, coef_in = 9'h000;
    wire result_ready, sample_ready, result_valid;
    wire [8:0] tap_out_first, tap_out_fourth, tap_out_seventh;
    wire [8:0] delayed_sample_out;
    wire [19:0] result_out;
    int error_cnt = 0, total_checks = 0, n_ev, n_pop, ign;
    int w [7];
    logic [8:0] raw [128];
    logic fmt [128];
    adaptive_fir_7tap u_dut (.core_clk, .rst, .sample_clock, .sample_in,
        .format_select, .load_clock, .load_enable, .coef_in, .result_ready,
        .sample_ready, .tap_out_first, .tap_out_fourth, .tap_out_seventh,
        .delayed_sample_out, .result_out, .result_valid);
    result_sink u_sink (.core_clk, .rst, .stall, .result_ready);
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(string nm, logic [19:0] seen, logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // history before reset reads as zero; cv picks the two's form
    function automatic logic [8:0] tc(int j, logic cv);
        if (j < 0)
            return 9'h000;
        return raw[j] ^ {cv & fmt[j], 8'h00};
    endfunction
    function automatic logic [19:0] exp_res(int p);
        int s = 0;
        for (int k = 0; k < 7; k++)
            s += $signed(tc(p - 11 - k, 1'b1)) * w[6 - k];
        return s[19:0];
    endfunction
    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        n_ev = 0;
        n_pop = 0;
        ign = 0;
        foreach (w[i]) w[i] = 0;
        #1;
        check("ready", sample_ready, 1'b1);
        check("valid", result_valid, 1'b0);
        check("seventh", tap_out_seventh, 9'h000);
    endtask
    // bogus coefficient while the load clock is high
    task automatic load(logic [8:0] c, logic en);
        @(posedge core_clk);
        load_clock <= 1'b1;
        coef_in <= ~c;
        @(posedge core_clk);
        load_clock <= 1'b0;
        load_enable <= en;
        coef_in <= c;
        @(posedge core_clk);
        load_enable <= 1'b0;
        if (en) begin
            for (int i = 0; i < 6; i++)
                w[i] = w[i + 1];
            w[6] = c[8] ? -int'(c[7:0]) : int'(c[7:0]);
        end
    endtask
    // one sample clock pulse, data valid only around the fall
    task automatic pulse(logic [8:0] v, logic f, logic st);
        logic ok;
        @(posedge core_clk);
        sample_clock <= 1'b1;
        sample_in <= ~v;
        stall <= st;
        @(posedge core_clk);
        sample_clock <= 1'b0;
        sample_in <= v;
        format_select <= f;
        #1 ok = sample_ready;
        @(posedge core_clk);
        #1;
        if (ok) begin
            raw[n_ev] = v;
            fmt[n_ev] = f;
            n_ev++;
        end
        check("first", tap_out_first, tc(n_ev - 4, 1'b1));
        check("fourth", tap_out_fourth, tc(n_ev - 5, 1'b1));
        check("seventh", tap_out_seventh, tc(n_ev - 10, 1'b1));
        check("delayed", delayed_sample_out, tc(n_ev - 10, 1'b0));
    endtask
    // every word handed downstream from pop number ign on is compared in pop order
    always @(posedge core_clk) begin
        if (!rst && result_valid && result_ready) begin
            if (n_pop >= ign)
                check("result", result_out, exp_res(n_pop));
            n_pop++;
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_stream();
        logic [8:0] cs [7] = '{9'h0ff, 9'h1ff, 9'h100, 9'h012, 9'h1a5,
            9'h07e, 9'h133};
        do_reset();
        for (int i = 0; i < 7; i++) begin
            load(cs[i], 1'b1);
            if (i == 3)
                load(9'h0aa, 1'b0);
        end
        for (int i = 0; i < 30; i++) begin
            pulse(9'(i * 75 + 256), 1'b0, i >= 12 && i < 18);
            if (i == 17)
                check("full", sample_ready, 1'b0);
        end
    endtask
    // reload while filtering; words mixing old and new sets are skipped
    task automatic s_reload();
        ign = 999;
        for (int i = 0; i < 7; i++) begin
            load(9'h0c3 ^ 9'(i * 41), 1'b1);
            pulse(9'(i * 19), 1'b1, 1'b0);
        end
        ign = n_ev + 18;
        for (int i = 0; i < 36; i++)
            pulse(9'(i * 53 + 7), 1'b1, 1'b0);
        repeat (8) @(posedge core_clk);
        check("pops", 20'(n_pop), 20'(n_ev));
    endtask
    task automatic s_midreset();
        for (int i = 0; i < 5; i++)
            pulse(9'h0f0, 1'b0, 1'b0);
        do_reset();
        // the line must restart from zero after a mid-run reset
        pulse(9'h0f0, 1'b0, 1'b0);
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        s_stream();
        s_reload();
        s_midreset();
        report_and_stop();
    end
    // cut a hang short well past the expected run length
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
